// ===== design/ssf_map.vh
// Register map, field positions and frame codes of the sample frame buffer.
// Assumes byte-wide storage and a 32-bit APB register port.
`ifndef SSF_MAP_VH
`define SSF_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSF_OFF_CFG     8'h00
`define SSF_OFF_WTM_LO  8'h04
`define SSF_OFF_WTM_HI  8'h08
`define SSF_OFF_LEN_LO  8'h0C
`define SSF_OFF_LEN_HI  8'h10
`define SSF_OFF_DATA    8'h14
`define SSF_OFF_CMD     8'h18
`define SSF_OFF_STAT    8'h1C
`define SSF_OFF_ERR     8'h20

// ----------------------------------------
// Configuration, status and error fields
// ----------------------------------------
`define SSF_CFG_STOP    0
`define SSF_CFG_TIME    1
`define SSF_CFG_HDR     2
`define SSF_CFG_ACC     3
`define SSF_CFG_AUX     4
`define SSF_CFG_TAG1    5
`define SSF_CFG_TAG2    6
`define SSF_CFG_IN1     7
`define SSF_CFG_IN2     8
`define SSF_CFG_LATCH   9
`define SSF_CFG_AUXSZ   10
`define SSF_CFG_W       12
`define SSF_CFG_RST     12'h0004
`define SSF_STAT_FULL   0
`define SSF_STAT_WTM    1
`define SSF_ERR_FIFO    0

// ----------------------------------------
// Commands, headers and payload bits
// ----------------------------------------
`define SSF_CMD_FLUSH   8'hB0
`define SSF_TYPE_REG    2'b10
`define SSF_TYPE_CTL    2'b01
`define SSF_OP_SKIP     4'h0
`define SSF_OP_TIME     4'h1
`define SSF_OP_CFG      4'h2
`define SSF_OP_DROP     4'h4
`define SSF_PRM_AUX     2
`define SSF_PRM_ACC     0
`define SSF_ICF_AUX_IF  5
`define SSF_ICF_AUX_CF  4
`define SSF_ICF_ACC_RG  1
`define SSF_ICF_ACC_CF  0
`define SSF_DROP_AUX    2
`define SSF_DROP_ACC    0
`define SSF_HDR_INVALID 8'h80
`define SSF_OVR_HDR     16'h0080
`define SSF_OVR_NOHDR   16'h8000
`define SSF_SKIP_MAX    8'hFF
`define SSF_ACC_BYTES   4'd6
`define SSF_MAX_FRAME   4'd15
`define SSF_CTL_LEN     4'd2

`endif

// ===== design/ssf_frame_fifo.v
// Frame buffer for accelerometer and auxiliary samples, read byte-wise over APB.
// Assumes one sample set per rate tick, ticks far apart compared with pclk.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "ssf_map.vh"

module ssf_frame_fifo #(
  parameter AW    = 10,
  parameter DEPTH = 1024
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        output_rate_tick,
  input  wire        acc_valid,
  input  wire [47:0] acc_sample,
  input  wire        aux_valid,
  input  wire [63:0] aux_sample,
  input  wire        acc_dropped,
  input  wire        aux_dropped,
  input  wire        aux_link_setup_changed,
  input  wire        aux_settings_changed,
  input  wire        accel_range_changed,
  input  wire        accel_settings_changed,
  input  wire        irq_pin_one,
  input  wire        irq_pin_two,
  input  wire [23:0] time_counter,
  output reg         full_int,
  output reg         watermark_int,
  output wire        fifo_error
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam W_IDLE = 3'b001;
  localparam W_MAKE = 3'b010;
  localparam W_PUT  = 3'b100;
  localparam S_MEM  = 3'd0;
  localparam S_SKH  = 3'd1;
  localparam S_SKC  = 3'd2;
  localparam S_TMH  = 3'd3;
  localparam S_TMB  = 3'd4;
  localparam S_OVR  = 3'd5;
  localparam [13:0] FULL_TH = DEPTH - 2 * `SSF_MAX_FRAME;

  // Aux bytes per frame from the burst size code
  function [3:0] aux_len;
    input [1:0] code;
    begin
      case (code)
        2'd0:    aux_len = 4'd1;
        2'd1:    aux_len = 4'd2;
        2'd2:    aux_len = 4'd6;
        default: aux_len = 4'd8;
      endcase
    end
  endfunction

  // Stored frame length from its first byte, or the fixed headerless size
  function [3:0] frame_len;
    input [7:0] hb;
    input       hdr;
    input       acc_on;
    input       aux_on;
    input [1:0] asz;
    begin
      if (!hdr)
        frame_len = (aux_on ? aux_len(asz) : 4'd0) + (acc_on ? `SSF_ACC_BYTES : 4'd0);
      else if (hb[7:6] == `SSF_TYPE_CTL)
        frame_len = `SSF_CTL_LEN;
      else
        frame_len = 4'd1 + (hb[2+`SSF_PRM_AUX] ? aux_len(asz) : 4'd0)
                    + (hb[2+`SSF_PRM_ACC] ? `SSF_ACC_BYTES : 4'd0);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [7:0]               mem [0:DEPTH-1];
  reg  [`SSF_CFG_W-1:0]    cfg_reg;
  reg  [`SSF_CFG_W-1:0]    cfg_prev_reg;
  reg  [7:0]               wtm_lo_reg;
  reg  [5:0]               wtm_hi_reg;
  reg  [AW:0]              wr_ptr_reg;
  reg  [AW:0]              rd_ptr_reg;
  reg  [AW:0]              fs_ptr_reg;
  reg  [3:0]               fpos_reg;
  reg  [3:0]               rlen_reg;
  reg                      burst_reg;
  reg                      sk_ph_reg;
  reg  [1:0]               tm_ph_reg;
  reg                      tm_done_reg;
  reg                      emptied_reg;
  reg                      ov_ph_reg;
  reg  [23:0]              ts_reg;
  reg  [2:0]               src_reg;
  reg  [7:0]               skip_reg;
  reg                      err_reg;
  reg  [2:0]               wst_reg;
  reg  [3:0]               wi_reg;
  reg  [3:0]               blen_reg;
  reg  [119:0]             wbuf_reg;
  reg                      tick_pend_reg;
  reg                      acc_v_reg;
  reg                      aux_v_reg;
  reg                      acc_d_reg;
  reg                      aux_d_reg;
  reg  [47:0]              acc_h_reg;
  reg  [63:0]              aux_h_reg;
  reg  [1:0]               tag_reg;
  reg  [7:0]               icf_reg;
  reg                      trans_reg;
  reg  [119:0]             df;
  reg  [3:0]               dlen;
  reg  [2:0]               cur_src;
  reg  [7:0]               cur_byte;
  reg  [31:0]              rd_mux;
  integer                  k;
  integer                  p;

  wire                     hdr       = cfg_reg[`SSF_CFG_HDR];
  wire                     acc_on    = cfg_reg[`SSF_CFG_ACC];
  wire                     aux_on    = cfg_reg[`SSF_CFG_AUX];
  wire [1:0]               asz       = cfg_reg[`SSF_CFG_AUXSZ+1:`SSF_CFG_AUXSZ];
  wire                     setup     = psel & ~penable;
  wire                     access    = psel & penable;
  wire                     wr_acc    = access & pwrite;
  wire                     rd_acc    = access & ~pwrite;
  wire                     data_rd   = rd_acc & (paddr == `SSF_OFF_DATA);
  wire                     reading   = burst_reg | (psel & (paddr == `SSF_OFF_DATA));
  wire [AW:0]              fill      = wr_ptr_reg - fs_ptr_reg;
  wire [13:0]              fill14    = {{(13-AW){1'b0}}, fill};
  wire [13:0]              wtm       = {wtm_hi_reg, wtm_lo_reg};
  wire                     low_space = (DEPTH - fill14) < {10'd0, `SSF_MAX_FRAME};
  wire                     cmd_flush = wr_acc & (paddr == `SSF_OFF_CMD) & (pwdata[7:0] == `SSF_CMD_FLUSH);
  wire [`SSF_CFG_W-1:0]    cdiff     = cfg_reg ^ cfg_prev_reg;
  wire                     auto_fl   = cdiff[`SSF_CFG_HDR] | cdiff[`SSF_CFG_AUXSZ] | cdiff[`SSF_CFG_AUXSZ+1]
                                       | (~hdr & (cdiff[`SSF_CFG_ACC] | cdiff[`SSF_CFG_AUX]));
  wire                     flush     = cmd_flush | auto_fl;
  wire                     skip_inc  = (wst_reg == W_MAKE) & low_space;
  wire                     skip_clr  = data_rd & (src_reg == S_SKC);
  wire                     cond_full = fill14 > FULL_TH;
  wire                     cond_wtm  = fill14 >= wtm;
  wire                     stat_rd   = rd_acc & (paddr == `SSF_OFF_STAT);
  wire [15:0]              ovr_word  = hdr ? `SSF_OVR_HDR : `SSF_OVR_NOHDR;
  wire [119:0]             wshift    = wbuf_reg >> {wi_reg, 3'b000};
  wire [3:0]               cur_len   = (fpos_reg == 4'd0) ?
                                       frame_len(mem[rd_ptr_reg[AW-1:0]], hdr, acc_on, aux_on, asz) : rlen_reg;
  wire [3:0]               del_len   = frame_len(mem[fs_ptr_reg[AW-1:0]], hdr, acc_on, aux_on, asz);
  wire                     mapped    = (paddr == `SSF_OFF_CFG) | (paddr == `SSF_OFF_WTM_LO)
                                       | (paddr == `SSF_OFF_WTM_HI) | (paddr == `SSF_OFF_LEN_LO)
                                       | (paddr == `SSF_OFF_LEN_HI) | (paddr == `SSF_OFF_DATA)
                                       | (paddr == `SSF_OFF_CMD) | (paddr == `SSF_OFF_STAT)
                                       | (paddr == `SSF_OFF_ERR);

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready     = 1'b1;
  assign pslverr    = access & ~mapped;
  assign fifo_error = err_reg;

  // ----------------------------------------
  // Frame assembly from one tick's samples
  // ----------------------------------------
  // All enabled sensors valid at the tick share one frame, so faster sensors ride along
  always @* begin
    df = 120'h0;
    p  = 0;
    if (hdr) begin
      df[7:0] = {`SSF_TYPE_REG, 1'b0, aux_v_reg & aux_on, 1'b0, acc_v_reg & acc_on, tag_reg};
      p       = 1;
    end
    if (aux_v_reg & aux_on) begin
      for (k = 0; k < 8; k = k + 1) begin
        if (k < aux_len(asz))
          df = df | ({112'h0, aux_h_reg[8*k +: 8]} << (8 * (p + k)));
      end
      p = p + aux_len(asz);
    end
    if (acc_v_reg & acc_on) begin
      df = df | ({72'h0, acc_h_reg} << (8 * p));
      p  = p + 6;
    end
    dlen = p[3:0];
  end

  // ----------------------------------------
  // Read source selection for the data register
  // ----------------------------------------
  always @* begin
    if (sk_ph_reg)
      cur_src = S_SKC;
    else if (!burst_reg && hdr && skip_reg != 8'h00)
      cur_src = S_SKH;
    else if (tm_ph_reg != 2'd0)
      cur_src = S_TMB;
    else if (rd_ptr_reg != wr_ptr_reg)
      cur_src = S_MEM;
    else if (hdr && cfg_reg[`SSF_CFG_TIME] && emptied_reg && !tm_done_reg)
      cur_src = S_TMH;
    else
      cur_src = S_OVR;
    case (cur_src)
      S_SKH:   cur_byte = {`SSF_TYPE_CTL, `SSF_OP_SKIP, 2'b00};
      S_SKC:   cur_byte = skip_reg;
      S_TMH:   cur_byte = {`SSF_TYPE_CTL, `SSF_OP_TIME, 2'b00};
      S_TMB:   cur_byte = ts_reg[8*(tm_ph_reg-2'd1) +: 8];
      S_MEM:   cur_byte = mem[rd_ptr_reg[AW-1:0]];
      default: cur_byte = ov_ph_reg ? ovr_word[15:8] : ovr_word[7:0];
    endcase
  end

  // Register read multiplexer
  always @* begin
    case (paddr)
      `SSF_OFF_CFG:    rd_mux = {{(32-`SSF_CFG_W){1'b0}}, cfg_reg};
      `SSF_OFF_WTM_LO: rd_mux = {24'h0, wtm_lo_reg};
      `SSF_OFF_WTM_HI: rd_mux = {26'h0, wtm_hi_reg};
      `SSF_OFF_LEN_LO: rd_mux = {24'h0, fill14[7:0]};
      `SSF_OFF_LEN_HI: rd_mux = {26'h0, fill14[13:8]};
      `SSF_OFF_DATA:   rd_mux = {24'h0, cur_byte};
      `SSF_OFF_STAT:   rd_mux = {30'h0, watermark_int, full_int};
      `SSF_OFF_ERR:    rd_mux = {31'h0, err_reg};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  // Read data is taken in the setup cycle, so the access edge sees it stable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h0000_0000;
      src_reg      <= S_OVR;
      cfg_reg      <= `SSF_CFG_RST;
      cfg_prev_reg <= `SSF_CFG_RST;
      wtm_lo_reg   <= 8'h00;
      wtm_hi_reg   <= 6'h00;
    end else begin
      cfg_prev_reg <= cfg_reg;
      if (setup && !pwrite) begin
        prdata  <= rd_mux;
        src_reg <= cur_src;
      end
      if (wr_acc && paddr == `SSF_OFF_CFG)
        cfg_reg <= pwdata[`SSF_CFG_W-1:0];
      if (wr_acc && paddr == `SSF_OFF_WTM_LO)
        wtm_lo_reg <= pwdata[7:0];
      if (wr_acc && paddr == `SSF_OFF_WTM_HI)
        wtm_hi_reg <= pwdata[5:0];
    end
  end

  // Skipped-frame counter; a new skip in the clearing cycle is kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_reg <= 8'h00;
    end else if (flush) begin
      skip_reg <= 8'h00;
    end else if (skip_inc) begin
      skip_reg <= skip_clr ? 8'h01 : (skip_reg == `SSF_SKIP_MAX ? skip_reg : skip_reg + 8'h01);
    end else if (skip_clr) begin
      skip_reg <= 8'h00;
    end
  end

  // Byte storage, no reset needed
  always @(posedge pclk) begin
    if (wst_reg == W_PUT)
      mem[wr_ptr_reg[AW-1:0] + {{(AW-4){1'b0}}, wi_reg}] <= wshift[7:0];
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Set beats clear; latched bits drop only after a status read below level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_int      <= 1'b0;
      watermark_int <= 1'b0;
    end else if (!cfg_reg[`SSF_CFG_LATCH]) begin
      full_int      <= cond_full & ~reading;
      watermark_int <= cond_wtm & ~reading;
    end else begin
      if (cond_full && !reading)
        full_int <= 1'b1;
      else if (stat_rd && !cond_full)
        full_int <= 1'b0;
      if (cond_wtm && !reading)
        watermark_int <= 1'b1;
      else if (stat_rd && !cond_wtm)
        watermark_int <= 1'b0;
    end
  end

  // ----------------------------------------
  // Writer, reader and pointers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg    <= {(AW+1){1'b0}};
      rd_ptr_reg    <= {(AW+1){1'b0}};
      fs_ptr_reg    <= {(AW+1){1'b0}};
      fpos_reg      <= 4'd0;
      rlen_reg      <= 4'd0;
      burst_reg     <= 1'b0;
      sk_ph_reg     <= 1'b0;
      tm_ph_reg     <= 2'd0;
      tm_done_reg   <= 1'b0;
      emptied_reg   <= 1'b0;
      ov_ph_reg     <= 1'b0;
      ts_reg        <= 24'h0;
      err_reg       <= 1'b0;
      wst_reg       <= W_IDLE;
      wi_reg        <= 4'd0;
      blen_reg      <= 4'd0;
      wbuf_reg      <= 120'h0;
      tick_pend_reg <= 1'b0;
      acc_v_reg     <= 1'b0;
      aux_v_reg     <= 1'b0;
      acc_d_reg     <= 1'b0;
      aux_d_reg     <= 1'b0;
      acc_h_reg     <= 48'h0;
      aux_h_reg     <= 64'h0;
      tag_reg       <= 2'b00;
      icf_reg       <= 8'h00;
      trans_reg     <= 1'b0;
    end else if (flush) begin
      wr_ptr_reg    <= {(AW+1){1'b0}};
      rd_ptr_reg    <= {(AW+1){1'b0}};
      fs_ptr_reg    <= {(AW+1){1'b0}};
      fpos_reg      <= 4'd0;
      sk_ph_reg     <= 1'b0;
      tm_ph_reg     <= 2'd0;
      tm_done_reg   <= 1'b0;
      emptied_reg   <= 1'b0;
      burst_reg     <= 1'b0;
      ov_ph_reg     <= 1'b0;
      wst_reg       <= W_IDLE;
      tick_pend_reg <= 1'b0;
      icf_reg       <= 8'h00;
      trans_reg     <= 1'b0;
    end else begin
      // Catch a tick's samples and the tags of enabled input pins
      if (output_rate_tick) begin
        tick_pend_reg <= 1'b1;
        acc_v_reg     <= acc_valid;
        aux_v_reg     <= aux_valid;
        acc_d_reg     <= acc_dropped;
        aux_d_reg     <= aux_dropped;
        acc_h_reg     <= acc_sample;
        aux_h_reg     <= aux_sample;
        tag_reg       <= {irq_pin_two & cfg_reg[`SSF_CFG_TAG2] & cfg_reg[`SSF_CFG_IN2],
                          irq_pin_one & cfg_reg[`SSF_CFG_TAG1] & cfg_reg[`SSF_CFG_IN1]};
      end
      // Collect configuration changes for the next config frame
      if (hdr) begin
        icf_reg[`SSF_ICF_AUX_IF] <= icf_reg[`SSF_ICF_AUX_IF] | aux_link_setup_changed;
        icf_reg[`SSF_ICF_AUX_CF] <= icf_reg[`SSF_ICF_AUX_CF] | aux_settings_changed;
        icf_reg[`SSF_ICF_ACC_RG] <= icf_reg[`SSF_ICF_ACC_RG] | accel_range_changed;
        icf_reg[`SSF_ICF_ACC_CF] <= icf_reg[`SSF_ICF_ACC_CF] | accel_settings_changed;
      end
      case (wst_reg)
        W_IDLE: begin
          // Config frame goes ahead of the first sample frame that follows
          if (hdr && icf_reg != 8'h00) begin
            wbuf_reg  <= {104'h0, icf_reg, `SSF_TYPE_CTL, `SSF_OP_CFG, 2'b00};
            blen_reg  <= `SSF_CTL_LEN;
            // A change pulse landing in the clearing cycle is kept for the next frame
            icf_reg   <= {2'b00, aux_link_setup_changed, aux_settings_changed,
                          2'b00, accel_range_changed, accel_settings_changed};
            trans_reg <= 1'b1;
            wst_reg   <= W_MAKE;
          end else if (tick_pend_reg) begin
            tick_pend_reg <= 1'b0;
            if (hdr && ((aux_v_reg & aux_on) | (acc_v_reg & acc_on))) begin
              wbuf_reg <= df;
              blen_reg <= dlen;
              if ((aux_v_reg | ~aux_on) & (acc_v_reg | ~acc_on))
                trans_reg <= 1'b0;
              wst_reg  <= W_MAKE;
            end else if (hdr && trans_reg && (acc_d_reg | aux_d_reg)) begin
              wbuf_reg <= {104'h0, 5'b0, aux_d_reg, 1'b0, acc_d_reg,
                           `SSF_TYPE_CTL, `SSF_OP_DROP, 2'b00};
              blen_reg <= `SSF_CTL_LEN;
              wst_reg  <= W_MAKE;
            end else if (!hdr && (aux_on | acc_on) && (aux_v_reg | ~aux_on) && (acc_v_reg | ~acc_on)) begin
              wbuf_reg <= df;
              blen_reg <= dlen;
              wst_reg  <= W_MAKE;
            end
          end
        end
        W_MAKE: begin
          wi_reg <= 4'd0;
          if (!low_space) begin
            wst_reg <= W_PUT;
          end else if (cfg_reg[`SSF_CFG_STOP] || reading) begin
            wst_reg <= W_IDLE;
            if (!cfg_reg[`SSF_CFG_STOP])
              err_reg <= 1'b1;
          end else begin
            fs_ptr_reg <= fs_ptr_reg + {{(AW-3){1'b0}}, del_len};
            rd_ptr_reg <= fs_ptr_reg + {{(AW-3){1'b0}}, del_len};
          end
        end
        W_PUT: begin
          wi_reg <= wi_reg + 4'd1;
          if (wi_reg == blen_reg - 4'd1) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-3){1'b0}}, blen_reg};  // Commit only whole frames
            wst_reg    <= W_IDLE;
          end
        end
        default: wst_reg <= W_IDLE;
      endcase
      // Error flag clears on read unless a new drop lands in the same cycle
      if (rd_acc && paddr == `SSF_OFF_ERR && !(wst_reg == W_MAKE && low_space && reading && !cfg_reg[`SSF_CFG_STOP]))
        err_reg <= 1'b0;
      // Data register reads advance the burst
      if (data_rd) begin
        burst_reg <= 1'b1;
        case (src_reg)
          S_SKH: sk_ph_reg <= 1'b1;
          S_SKC: sk_ph_reg <= 1'b0;
          S_TMH: tm_ph_reg <= 2'd1;
          S_TMB: begin
            tm_ph_reg <= (tm_ph_reg == 2'd3) ? 2'd0 : tm_ph_reg + 2'd1;
            if (tm_ph_reg == 2'd3)
              tm_done_reg <= 1'b1;
          end
          S_MEM: begin
            if (rd_ptr_reg != wr_ptr_reg) begin
              rd_ptr_reg <= rd_ptr_reg + 1'b1;
              rlen_reg   <= cur_len;
              if (fpos_reg == cur_len - 4'd1) begin
                fpos_reg   <= 4'd0;
                fs_ptr_reg <= rd_ptr_reg + 1'b1;
                if (rd_ptr_reg + 1'b1 == wr_ptr_reg) begin
                  ts_reg      <= time_counter;
                  emptied_reg <= 1'b1;
                end
              end else begin
                fpos_reg <= fpos_reg + 4'd1;
              end
            end
          end
          default: ov_ph_reg <= ~ov_ph_reg;
        endcase
      end else if (access && paddr != `SSF_OFF_DATA && burst_reg) begin
        // An access to any other register ends the burst; an unfinished frame is rewound
        burst_reg   <= 1'b0;
        sk_ph_reg   <= 1'b0;
        tm_ph_reg   <= 2'd0;
        tm_done_reg <= 1'b0;
        emptied_reg <= 1'b0;
        ov_ph_reg   <= 1'b0;
        fpos_reg    <= 4'd0;
        rd_ptr_reg  <= fs_ptr_reg;
      end
    end
  end

endmodule

// ===== testbench/ssf_properties.sv
// Checker for the frame buffer register port and flags.
// Assumes byte addresses on paddr and the map of the design header.
`timescale 1ns/1ps
module ssf_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        full_int,
  input wire logic        watermark_int,
  input wire logic        fifo_error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states, so the master never stalls
  a_ready_high: assert property (pready) else $error("ready low");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr) else $error("no slverr");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray slverr");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h20 |=> prdata == 32'h0)
    else $error("unmapped data");
  // Read data only moves after a setup cycle
  a_read_hold: assert property ($changed(prdata) |-> $past(psel && !penable)) else $error("prdata moved");
  a_quiet_read: assert property (psel && paddr == 8'h14 |=> !$rose(full_int) && !$rose(watermark_int))
    else $error("irq during read");
  a_err_sticky: assert property ($fell(fifo_error) |-> $past(psel && penable && paddr == 8'h20))
    else $error("error flag lost");
  a_flush_empty: assert property (psel && penable && pwrite && paddr == 8'h18 && pwdata[7:0] == 8'hB0
    ##1 psel && !penable && !pwrite && paddr == 8'h0C |=> prdata == 32'h0) else $error("flush left data");
endmodule
bind ssf_frame_fifo ssf_props ssf_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .full_int, .watermark_int, .fifo_error);

// ===== testbench/ssf_sensor_model.sv
// Sensor front end: rate ticks and accelerometer samples.
// Assumes fire is a one-cycle request from the bench.
`timescale 1ns/1ps
module ssf_sensor_model (
  input  wire logic        pclk,
  input  wire logic        fire,
  output logic             tick,
  output logic [47:0]      acc_sample
);
  logic [7:0] seq = 8'h5A;
  // Alternating bytes so a swapped byte order shows
  assign acc_sample = {seq, ~seq, seq, ~seq, seq, ~seq};
  always @(posedge pclk) begin
    tick <= fire;
    if (tick)
      seq <= seq + 8'h01;
  end
endmodule

// ===== testbench/test_ssf_frame_fifo.sv
// Bench for the frame buffer: APB tasks and frame readout checks.
// Assumes 200 MHz pclk and a 64-byte buffer.
`timescale 1ns/1ps
module test_ssf_frame_fifo;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        fire = 0, chg = 0, pin = 1, av = 1, ad = 0, tick, pready, pslverr, full_int, watermark_int, fifo_error;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [23:0] tc = 0;
  logic [47:0] acc_sample;
  int          mismatches = 0, n_checks = 0, n;
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) tc <= tc + 24'h1;
  ssf_sensor_model ssf_sensor_model_inst (.pclk, .fire, .tick, .acc_sample);
  ssf_frame_fifo #(.AW(6), .DEPTH(64)) ssf_frame_fifo_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .output_rate_tick(tick), .acc_valid(av), .acc_sample,
    .aux_valid(1'h0), .aux_sample(64'h0), .acc_dropped(ad), .aux_dropped(1'h0),
    .aux_link_setup_changed(chg), .aux_settings_changed(chg), .accel_range_changed(chg),
    .accel_settings_changed(chg), .irq_pin_one(pin), .irq_pin_two(pin), .time_counter(tc),
    .full_int, .watermark_int, .fifo_error);
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One transfer; caller follows with another transfer or idle, never a double drive
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      mismatches++;
      conclude;
    end
    else if (!w)
      chk("register", prdata, e);
  endtask
  task automatic idle(input int c);
    {psel, penable} <= 2'b00;
    repeat (c) @(posedge pclk);
  endtask
  // Rate tick, then room for the frame to be stored
  task automatic shot;
    fire <= 1;
    @(posedge pclk) fire <= 0;
    repeat (30) @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 8'h00, 0, 32'h0000_0004);
    xfer(0, 8'h24, 0, 32'h0000_0000);
    chk("slverr", {31'h0, pslverr}, 32'h1);
    xfer(1, 8'h00, 32'h0000_01EC, 0);
    xfer(1, 8'h04, 32'h0000_0007, 0);
    idle(1);
    chg <= 1;
    @(posedge pclk) chg <= 0;
    shot;
    xfer(0, 8'h0C, 0, 32'h0000_0009);
    chk("watermark", {31'h0, watermark_int}, 32'h1);
    xfer(0, 8'h14, 0, 32'h0000_0048);
    xfer(0, 8'h14, 0, 32'h0000_0033);
    xfer(0, 8'h14, 0, 32'h0000_0087);
    xfer(0, 8'h0C, 0, 32'h0000_0007);
    xfer(0, 8'h14, 0, 32'h0000_0087);
    for (int i = 0; i < 6; i++)
      xfer(0, 8'h14, 0, {24'h0, i[0] ? 8'h5A : 8'hA5});
    xfer(0, 8'h14, 0, 32'h0000_0080);
    xfer(0, 8'h14, 0, 32'h0000_0000);
    idle(1);
    shot;
    xfer(1, 8'h18, 32'h0000_00B0, 0);
    xfer(0, 8'h0C, 0, 32'h0000_0000);
    idle(3);
    chk("watermark", {31'h0, watermark_int}, 32'h0);
    // Config change, then a tick with the only sensor dropped
    av <= 0;
    ad <= 1;
    chg <= 1;
    @(posedge pclk) chg <= 0;
    shot;
    av <= 1;
    ad <= 0;
    xfer(0, 8'h0C, 0, 32'h0000_0004);
    xfer(0, 8'h14, 0, 32'h0000_0048);
    xfer(0, 8'h14, 0, 32'h0000_0033);
    xfer(0, 8'h14, 0, 32'h0000_0050);
    xfer(0, 8'h14, 0, 32'h0000_0001);
    xfer(0, 8'h20, 0, 32'h0000_0000);
    idle(1);
    // Five 7-byte frames pass the full threshold, four do not
    repeat (4) shot;
    chk("full", {31'h0, full_int}, 32'h0);
    shot;
    chk("full", {31'h0, full_int}, 32'h1);
    xfer(0, 8'h14, 0, 32'h0000_0087);
    chk("full", {31'h0, full_int}, 32'h0);
    idle(1);
    // Overflow while a burst is open: new frame dropped, error flagged
    repeat (4) shot;
    xfer(0, 8'h20, 0, 32'h0000_0001);
    xfer(0, 8'h14, 0, 32'h0000_0040);
    xfer(0, 8'h14, 0, 32'h0000_0001);
    xfer(0, 8'h14, 0, 32'h0000_0087);
    xfer(0, 8'h20, 0, 32'h0000_0000);
    xfer(0, 8'h14, 0, 32'h0000_0087);
    idle(1);
    conclude;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    conclude;
  end
endmodule
